// ===== hw/pfc_defines.vh
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH
// Register byte offsets
`define PFC_CTRLA_OFS 12'h000
`define PFC_CTRLB_OFS 12'h004
`define PFC_COUNT_OFS 12'h008
`define PFC_CMPA_OFS 12'h00C
`define PFC_CMPB_OFS 12'h010
`define PFC_CMPC_OFS 12'h014
`define PFC_CAPT_OFS 12'h018
`define PFC_FLAGS_OFS 12'h01C
`define PFC_DIR_OFS 12'h020
// Control A fields: mode A 7:6, B 5:4, C 3:2, low mode bits 1:0
`define PFC_COMA_HI 7
`define PFC_COMB_HI 5
`define PFC_COMC_HI 3
`define PFC_WGM_LO_HI 1
// Control B fields: high mode bits 4:3, prescaler select 2:0
`define PFC_WGM_HI_HI 4
`define PFC_CS_HI 2
// Flag bits
`define PFC_FLG_OVF 0
`define PFC_FLG_CMPA 1
`define PFC_FLG_CMPB 2
`define PFC_FLG_CMPC 3
`define PFC_FLG_CAPT 4
// Mode codes
`define PFC_MODE_CAPT_TOP 4'h8
`define PFC_MODE_CMPA_TOP 4'h9
// Compare output modes
`define PFC_COM_OFF 2'h0
`define PFC_COM_TOGGLE 2'h1
`define PFC_COM_NONINV 2'h2
`define PFC_COM_INV 2'h3
// Prescaler select codes
`define PFC_CS_STOP 3'h0
`define PFC_CS_DIV1 3'h1
`define PFC_CS_DIV8 3'h2
`define PFC_CS_DIV64 3'h3
`define PFC_CS_DIV256 3'h4
`define PFC_CS_DIV1024 3'h5
// Reset values
`define PFC_RST_TOP 16'hFFFF
`define PFC_HTRANS_NONSEQ 2'h2
`endif

// ===== hw/pfc_timer.v
// Overview of operation
// R1: Modes 8 and 9 run dual slope; TOP from capture value or compare A.
// R2: Count rises from zero to TOP, then falls back to zero, repeatedly.
// R3: Count holds TOP for one tick, then turns downward.
// R4: Non-inverting clears on up-match, sets on down-match; inverting opposite.
// R5: Output mode 2 gives non-inverted PWM, 3 gives inverted PWM.
// R6: Pin level reaches the pad only when its direction bit is output.
// R7: TOP accepts values from 0x0003 up to 0xFFFF.
// R8: Compare writes go to buffers; active values load at count zero.
// R9: Overflow flag sets in the tick the buffers load at bottom.
// R10: Compare A or capture flag sets at TOP when that register is TOP.
// R11: Channel match flag sets on equality on both slopes.
// R12: Software keeps TOP at or above compares; above TOP never matches.
// R13: Compare zero gives low, compare TOP gives high, inverted opposite.
// R14: Tick comes from the clock divided by 1, 8, 64, 256 or 1024.
// R15: Period lasts twice prescale times TOP clock cycles.
// R16: Fully synchronous; the tick is a clock enable, not a clock.
// R17: Software uses capture value for fixed TOP, compare A for changing TOP.
// R18: Mode 0 disconnects; mode 1 toggles A when top mode bit set.
// R19: Mode code split: low bits in control A 1:0, high in control B.
// R20: Direction starts up-counting after reset and on entering the mode; a count write in the entry cycle keeps the old direction.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_timer #(
    parameter WIDTH = 16,
    parameter NCH = 3
) (
    input wire clk_i,
    input wire reset_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hsel_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [NCH-1:0] compare_output_pin_o,
    output reg [NCH-1:0] compare_output_oe_o
);
    // Bus address phase capture
    reg wr_pend_ff;
    reg [11:0] wr_addr_ff;
    reg [7:0] ctrla_ff;
    reg [4:0] ctrlb_ff;
    reg [WIDTH-1:0] count_ff;
    reg dir_down_ff;
    reg [WIDTH-1:0] cmp_buf_ff [0:NCH-1];
    reg [WIDTH-1:0] cmp_act_ff [0:NCH-1];
    reg [WIDTH-1:0] capt_ff;
    reg [4:0] flags_ff;
    reg [NCH-1:0] dir_bits_ff;
    reg [NCH-1:0] wave_ff;
    reg [9:0] pre_ff;
    reg was_pfc_ff;
    wire [3:0] mode_code;
    wire pfc_mode;
    wire [WIDTH-1:0] top_val;
    reg tick;
    wire [NCH-1:0] match;
    wire at_top;
    wire at_bottom;
    wire bus_req;
    wire [11:0] wadr;
    wire [4:0] flag_clr;
    wire [4:0] flag_set;
    reg [31:0] nxt_rdata;
    reg [WIDTH-1:0] nxt_count;
    reg nxt_dir_down;
    reg [NCH-1:0] nxt_wave;
    reg [4:0] nxt_flags;
    wire slope_down;
    integer k;
    integer j;

    // Output mode field of a channel
    function [1:0] com_of;
        input [7:0] ca;
        input integer ch;
        begin
            com_of = ca[`PFC_COMA_HI - 2*ch -: 2];
        end
    endfunction

    // Full mode code assembled from the two control registers
    assign mode_code = {ctrlb_ff[`PFC_WGM_HI_HI -: 2], ctrla_ff[`PFC_WGM_LO_HI -: 2]}; // R19
    assign pfc_mode = (mode_code == `PFC_MODE_CAPT_TOP) || (mode_code == `PFC_MODE_CMPA_TOP); // R1
    // TOP from active compare A in mode 9, else capture value
    assign top_val = (mode_code == `PFC_MODE_CMPA_TOP) ? cmp_act_ff[0] : capt_ff; // R1 R7
    assign at_top = (count_ff == top_val);
    assign at_bottom = (count_ff == {WIDTH{1'b0}});
    // TOP closes the rising slope and zero the falling one, so both ends act as turns
    assign slope_down = at_top ? 1'b1 : (at_bottom ? 1'b0 : dir_down_ff); // R4 R13
    assign bus_req = hsel_i && hready_i && htrans_i[1];
    assign wadr = wr_addr_ff;

    // Prescaler tick; free running divider, one-cycle enable
    always @*
    begin
        case (ctrlb_ff[`PFC_CS_HI -: 3])
            `PFC_CS_DIV1: tick = 1'b1; // R14
            `PFC_CS_DIV8: tick = (pre_ff[2:0] == 3'h7);
            `PFC_CS_DIV64: tick = (pre_ff[5:0] == 6'h3F);
            `PFC_CS_DIV256: tick = (pre_ff[7:0] == 8'hFF);
            `PFC_CS_DIV1024: tick = (pre_ff == 10'h3FF);
            default: tick = 1'b0;
        endcase
    end

    always @(posedge clk_i)
    begin
        if (reset_i)
            pre_ff <= 10'h000;
        else
            pre_ff <= pre_ff + 10'h001; // R16
    end

    // Match per channel; a compare above TOP is never reached
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_match
            assign match[g] = pfc_mode && (count_ff == cmp_act_ff[g]) && (cmp_act_ff[g] <= top_val); // R11 R12
        end
    endgenerate

    // Flag events, each qualified by the tick
    assign flag_set[`PFC_FLG_OVF] = tick && pfc_mode && at_bottom; // R9
    assign flag_set[`PFC_FLG_CMPA] = tick && (match[0] || (pfc_mode && (mode_code == `PFC_MODE_CMPA_TOP) && at_top)); // R10 R11
    assign flag_set[`PFC_FLG_CMPB] = tick && match[1]; // R11
    assign flag_set[`PFC_FLG_CMPC] = tick && match[2]; // R11
    assign flag_set[`PFC_FLG_CAPT] = tick && pfc_mode && (mode_code == `PFC_MODE_CAPT_TOP) && at_top; // R10
    assign flag_clr = (wr_pend_ff && wadr == `PFC_FLAGS_OFS) ? hwdata_i[4:0] : 5'h00;

    // Next flags; write-one-to-clear, a set in the same cycle wins
    always @*
    begin
        nxt_flags = (flags_ff & ~flag_clr) | flag_set;
    end

    // Next count and direction; TOP and zero each last exactly one tick
    always @*
    begin
        nxt_count = count_ff;
        nxt_dir_down = dir_down_ff;
        if (wr_pend_ff && wadr == `PFC_COUNT_OFS)
        begin
            // Software write wins over the tick
            nxt_count = hwdata_i[WIDTH-1:0];
        end
        else if (pfc_mode && !was_pfc_ff)
        begin
            nxt_dir_down = 1'b0; // R20
        end
        else if (tick && pfc_mode) // R16
        begin
            if (!dir_down_ff)
            begin
                if (at_top || count_ff > top_val)
                begin
                    // Turn at TOP; a count left above a lowered TOP falls back too
                    nxt_dir_down = 1'b1; // R3
                    nxt_count = count_ff - 1'b1; // R2
                end
                else
                begin
                    nxt_count = count_ff + 1'b1; // R2
                end
            end
            else
            begin
                if (at_bottom)
                begin
                    // Zero is seen once, so a period is 2*TOP ticks
                    nxt_dir_down = 1'b0; // R2 R15
                    nxt_count = count_ff + 1'b1; // R15
                end
                else
                begin
                    nxt_count = count_ff - 1'b1; // R2
                end
            end
        end
    end

    // Counter, direction and mode-entry registers
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count_ff <= {WIDTH{1'b0}};
            dir_down_ff <= 1'b0; // R20
            was_pfc_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            dir_down_ff <= nxt_dir_down;
            was_pfc_ff <= pfc_mode;
        end
    end

    // Compare buffers, active copies, capture value, control
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctrla_ff <= 8'h00;
            ctrlb_ff <= 5'h00;
            capt_ff <= `PFC_RST_TOP;
            dir_bits_ff <= {NCH{1'b0}};
            flags_ff <= 5'h00;
            for (k = 0; k < NCH; k = k + 1)
            begin
                cmp_buf_ff[k] <= {WIDTH{1'b0}};
                cmp_act_ff[k] <= {WIDTH{1'b0}};
            end
        end
        else
        begin
            flags_ff <= nxt_flags;
            if (wr_pend_ff && wadr == `PFC_CTRLA_OFS)
                ctrla_ff <= hwdata_i[7:0];
            if (wr_pend_ff && wadr == `PFC_CTRLB_OFS)
                ctrlb_ff <= hwdata_i[4:0];
            if (wr_pend_ff && wadr == `PFC_CAPT_OFS)
                capt_ff <= hwdata_i[WIDTH-1:0]; // R7
            if (wr_pend_ff && wadr == `PFC_DIR_OFS)
                dir_bits_ff <= hwdata_i[NCH-1:0];
            for (k = 0; k < NCH; k = k + 1)
            begin
                if (wr_pend_ff && wadr == (`PFC_CMPA_OFS + 4*k))
                    cmp_buf_ff[k] <= hwdata_i[WIDTH-1:0]; // R8
                // Load at bottom keeps both slopes equal
                if (tick && pfc_mode && at_bottom)
                    cmp_act_ff[k] <= cmp_buf_ff[k]; // R8 R9
                else if (!pfc_mode)
                    cmp_act_ff[k] <= cmp_buf_ff[k];
            end
        end
    end

    // Next waveform level; non-inverting, a match at TOP sets and one at zero clears; inverting, the reverse
    always @*
    begin
        nxt_wave = wave_ff;
        for (j = 0; j < NCH; j = j + 1)
        begin
            if (tick && match[j])
            begin
                case (com_of(ctrla_ff, j))
                    `PFC_COM_NONINV: nxt_wave[j] = slope_down; // R4 R5 R13
                    `PFC_COM_INV: nxt_wave[j] = !slope_down; // R4 R5 R13
                    `PFC_COM_TOGGLE:
                    begin
                        if (j == 0 && mode_code[3])
                            nxt_wave[j] = !wave_ff[j]; // R18
                    end
                    default: nxt_wave[j] = wave_ff[j];
                endcase
            end
        end
    end

    // Waveform register
    always @(posedge clk_i)
    begin
        if (reset_i)
            wave_ff <= {NCH{1'b0}};
        else
            wave_ff <= nxt_wave;
    end

    // Pad registers; level lags the waveform by one clock to keep outputs registered
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            compare_output_pin_o <= {NCH{1'b0}};
            compare_output_oe_o <= {NCH{1'b0}};
        end
        else
        begin
            compare_output_pin_o <= wave_ff;
            // Reserved toggle on B and C leaves the pad undriven
            for (k = 0; k < NCH; k = k + 1)
            begin
                compare_output_oe_o[k] <= dir_bits_ff[k] && (com_of(ctrla_ff, k) != `PFC_COM_OFF) &&
                    !(k != 0 && com_of(ctrla_ff, k) == `PFC_COM_TOGGLE); // R6 R18
            end
        end
    end

    // Read mux, unmapped reads as zero
    always @*
    begin
        nxt_rdata = 32'h00000000;
        case (haddr_i[11:0])
            `PFC_CTRLA_OFS: nxt_rdata = {24'h000000, ctrla_ff};
            `PFC_CTRLB_OFS: nxt_rdata = {27'h0000000, ctrlb_ff};
            `PFC_COUNT_OFS: nxt_rdata = {{(32-WIDTH){1'b0}}, count_ff};
            `PFC_CMPA_OFS: nxt_rdata = {{(32-WIDTH){1'b0}}, cmp_buf_ff[0]};
            `PFC_CMPB_OFS: nxt_rdata = {{(32-WIDTH){1'b0}}, cmp_buf_ff[1]};
            `PFC_CMPC_OFS: nxt_rdata = {{(32-WIDTH){1'b0}}, cmp_buf_ff[2]};
            `PFC_CAPT_OFS: nxt_rdata = {{(32-WIDTH){1'b0}}, capt_ff};
            `PFC_FLAGS_OFS: nxt_rdata = {27'h0000000, flags_ff};
            `PFC_DIR_OFS: nxt_rdata = {{(32-NCH){1'b0}}, dir_bits_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // AHB-Lite slave, zero wait states, always OKAY
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
        else
        begin
            wr_pend_ff <= bus_req && hwrite_i;
            if (bus_req)
                wr_addr_ff <= haddr_i[11:0];
            if (bus_req && !hwrite_i)
                hrdata_o <= nxt_rdata;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end
endmodule

// ===== tb/pfc_timer_asserts.sv
`timescale 1ns/100ps
module pfc_timer_asserts (
    input wire clk_i,
    input wire reset_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hsel_i,
    input wire hready_i,
    input wire [31:0] hrdata_o,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [2:0] compare_output_pin_o,
    input wire [2:0] compare_output_oe_o
);
    // Transfers taken in their address phase
    wire rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    wire wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    reg wr_ff;
    // Write data phase marker; config outputs may only move after one
    always @(posedge clk_i)
    begin
        wr_ff <= wr_take && !reset_i;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_rd(ofs);
        rd_take && haddr_i[11:0] == ofs;
    endsequence
    sequence s_hole;
        rd_take && haddr_i[11:0] > 12'h020;
    endsequence
    bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
    rdata_hold_a: assert property ($changed(hrdata_o) |-> $past(rd_take)) else $error("read data moved alone");
    reset_clear_a: assert property (disable iff (1'b0) reset_i |=> hrdata_o == 32'h0 &&
        compare_output_oe_o == 3'h0 && compare_output_pin_o == 3'h0) else $error("outputs not cleared");
    hole_read_a: assert property (s_hole |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
    ctrl_width_a: assert property (s_rd(12'h000) |=> hrdata_o[31:8] == 24'h0) else $error("control too wide");
    count_width_a: assert property (s_rd(12'h008) |=> hrdata_o[31:16] == 16'h0) else $error("count too wide");
    flag_width_a: assert property (s_rd(12'h01C) |=> hrdata_o[31:5] == 27'h0) else $error("flags too wide");
    oe_cause_a: assert property ($changed(compare_output_oe_o) |->
        $past(wr_ff) || $past(wr_ff, 2) || $past(wr_ff, 3)) else $error("drive enable moved alone");
endmodule
bind pfc_timer pfc_timer_asserts pfc_timer_asserts_i (.clk_i(clk_i), .reset_i(reset_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsel_i(hsel_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .compare_output_pin_o(compare_output_pin_o),
    .compare_output_oe_o(compare_output_oe_o));

// ===== tb/test_pfc_timer.sv
`timescale 1ns/100ps
`include "pfc_defines.vh"
module test_pfc_timer;
    reg clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hready;
    wire hresp;
    wire [2:0] pin;
    wire [2:0] oe;
    integer fail_count = 0;
    integer checks = 0;
    integer cycles = 0;
    reg [31:0] rv;
    integer per;
    integer hi;
    integer k;
    integer n;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    pfc_timer pfc_timer_i (.clk_i(clk_i), .reset_i(reset_i), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hsel_i(1'b1), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .compare_output_pin_o(pin), .compare_output_oe_o(oe));
    task chk(input [31:0] g, input [31:0] e);
    begin
        checks = checks + 1;
        if (g !== e)
        begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            fail_count = fail_count + 1;
        end
    end
    endtask
    // One single transfer; waits on hready although the slave adds none
    task xfer(input w, input [11:0] a, input [31:0] d);
    begin
        haddr <= {20'h0, a};
        htrans <= `PFC_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rv = hrdata;
    end
    endtask
    // Rise to rise of one pin; the first partial period is skipped
    task measure(input integer ch);
    begin
        hi = 0;
        while (pin[ch] !== 1'b0) @(posedge clk_i);
        while (pin[ch] !== 1'b1) @(posedge clk_i);
        while (pin[ch] !== 1'b0)
        begin
            @(posedge clk_i);
            hi = hi + 1;
        end
        per = hi;
        while (pin[ch] !== 1'b1)
        begin
            @(posedge clk_i);
            per = per + 1;
        end
    end
    endtask
    // High cycles over a fixed window, unknown poisons the sum
    task window(input integer ch, input integer len);
    begin
        hi = 0;
        repeat (len)
        begin
            @(posedge clk_i);
            hi = hi + pin[ch];
        end
    end
    endtask
    task t_reset;
    begin
        xfer(0, `PFC_CAPT_OFS, 0);
        chk(rv, 32'h0000FFFF);
        xfer(0, `PFC_CTRLA_OFS, 0);
        chk(rv, 32'h0);
        xfer(0, 12'h030, 0);
        chk(rv, 32'h0);
        xfer(1, `PFC_CTRLB_OFS, 32'h1);
        repeat (8) @(posedge clk_i);
        xfer(0, `PFC_COUNT_OFS, 0);
        chk(rv, 32'h0);
        $display("reset test done");
    end
    endtask
    task t_pwm;
    begin
        xfer(1, `PFC_CAPT_OFS, 32'h3);
        xfer(1, `PFC_CMPB_OFS, 32'h1);
        xfer(1, `PFC_CMPC_OFS, 32'h1);
        xfer(1, `PFC_DIR_OFS, 32'h7);
        xfer(1, `PFC_CTRLA_OFS, 32'h2C);
        for (k = 1; k <= 5; k = k + 1)
        begin
            n = (k == 1) ? 1 : (k == 2) ? 8 : (k == 3) ? 64 : (k == 4) ? 256 : 1024;
            xfer(1, `PFC_CTRLB_OFS, 32'h10 | k);
            measure(1);
            measure(1);
            chk(per, 6 * n);
            chk(hi, 2 * n);
            measure(2);
            chk(hi, 4 * n);
        end
        chk(oe, 32'h6);
        xfer(1, `PFC_CTRLB_OFS, 32'h11);
        xfer(1, `PFC_CMPB_OFS, 32'h2);
        measure(1);
        measure(1);
        chk(hi, 4);
        $display("pwm test done");
    end
    endtask
    task t_extreme;
    begin
        xfer(1, `PFC_CMPB_OFS, 32'h0);
        xfer(1, `PFC_CMPC_OFS, 32'h0);
        repeat (20) @(posedge clk_i);
        window(1, 24);
        chk(hi, 0);
        window(2, 24);
        chk(hi, 24);
        $display("extreme test done");
    end
    endtask
    task t_flags;
    begin
        xfer(1, `PFC_CMPA_OFS, 32'h5);
        xfer(1, `PFC_CMPB_OFS, 32'h1);
        xfer(1, `PFC_CMPC_OFS, 32'h2);
        repeat (20) @(posedge clk_i);
        xfer(1, `PFC_CTRLB_OFS, 32'h10);
        xfer(1, `PFC_FLAGS_OFS, 32'h1F);
        xfer(0, `PFC_FLAGS_OFS, 0);
        chk(rv, 32'h0);
        xfer(1, `PFC_CTRLB_OFS, 32'h11);
        repeat (20) @(posedge clk_i);
        xfer(1, `PFC_CTRLB_OFS, 32'h10);
        xfer(0, `PFC_FLAGS_OFS, 0);
        chk(rv, 32'h1D);
        xfer(1, `PFC_CMPA_OFS, 32'h3);
        xfer(1, `PFC_CTRLA_OFS, 32'h2D);
        xfer(1, `PFC_FLAGS_OFS, 32'h1F);
        xfer(1, `PFC_CTRLB_OFS, 32'h11);
        repeat (30) @(posedge clk_i);
        xfer(1, `PFC_CTRLB_OFS, 32'h10);
        xfer(0, `PFC_FLAGS_OFS, 0);
        chk(rv & 32'hF, 32'hF);
        $display("flag test done");
    end
    endtask
    task t_oe;
    begin
        xfer(1, `PFC_CTRLA_OFS, 32'h44);
        repeat (4) @(posedge clk_i);
        chk(oe, 32'h1);
        xfer(1, `PFC_DIR_OFS, 32'h6);
        repeat (4) @(posedge clk_i);
        chk(oe, 32'h0);
        $display("drive test done");
    end
    endtask
    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Hang guard, well above the longest expected run
    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 90000)
        begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_pwm;
        t_extreme;
        t_flags;
        t_oe;
        tally_and_finish;
    end
endmodule
